// file: src/idr_top.sv
/*
 Identify data responder: APB slave that takes the identify command, fills
 the sector buffer with the parameter block and hands it out word by word.
 Assumes one clock pclk, asynchronous active-low presetn, APB master.
*/
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module idr_top #(
	parameter int WORDS = 256,
	parameter logic [159:0] SERIAL_STR = "0123456789ABCDEFGHIJ",
	parameter logic [63:0] FW_STR = "REV00001",
	parameter logic [319:0] MODEL_STR = {"GENERIC DISK DRIVE  ", "                    "}
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	localparam logic [7:0] LAST = 8'(WORDS - 1); // Index of the final word

	// The word index is eight bits and the block must reach word 56
	generate
		if (WORDS < 64 || WORDS > 256) begin : g_bad_words
			$error("idr_top: WORDS must lie in 64..256");
		end
	endgenerate

	idr_pkg::idr_state_e state_r; // Sequencer state
	logic bsy_r; // Busy flag
	logic drq_r; // Data request flag
	logic [7:0] widx_r; // Fill index
	logic [7:0] rptr_r; // Host read pointer
	logic [7:0] last_cmd_r; // Last command code written
	logic ev_ready_d_r; // Final fill word one cycle ago; rises on the same edge as DRQ
	logic [idr_pkg::IDR_INT_W-1:0] int_stat_r; // Sticky events
	logic [idr_pkg::IDR_INT_W-1:0] int_mask_r; // Interrupt enables
	logic [idr_pkg::IDR_INT_W-1:0] int_ev; // Event pulses
	idr_pkg::idr_cfg_s cfg_r; // Geometry and multiple limit
	logic [31:0] prdata_r; // Read data to bus
	logic pready_r; // Access completes
	logic pslverr_r; // Unmapped address
	logic irq_r; // Interrupt line
	logic [31:0] rd_val; // Read multiplexer
	logic [15:0] gen_word; // Generated parameter word
	logic [15:0] buf_word; // Word at the read pointer
	logic acc; // Transfer completes this edge
	logic wr_go; // Completing write
	logic rd_go; // Completing read
	logic cmd_write; // Write to command register
	logic cmd_take; // Identify accepted
	logic cmd_refuse; // Command refused
	logic fill_we; // Buffer write strobe
	logic fill_last; // Final word being written
	logic pop; // Data word consumed
	logic pop_last; // Final word consumed

	// Offsets that answer without error
	function automatic logic hit_map(input logic [7:0] a);
		case (a)
			idr_pkg::IDR_OFF_CMD, idr_pkg::IDR_OFF_STATUS, idr_pkg::IDR_OFF_DATA,
			idr_pkg::IDR_OFF_INT_STAT, idr_pkg::IDR_OFF_INT_MASK,
			idr_pkg::IDR_OFF_DEF_CYL, idr_pkg::IDR_OFF_DEF_HS,
			idr_pkg::IDR_OFF_CUR_CYL, idr_pkg::IDR_OFF_CUR_HS,
			idr_pkg::IDR_OFF_MULT: hit_map = 1'b1;
			default: hit_map = 1'b0;
		endcase
	endfunction : hit_map

	// Bus strobes; side effects act only on the completing edge
	assign acc = psel & penable & pready_r;
	assign wr_go = acc & pwrite;
	assign rd_go = acc & ~pwrite;
	assign cmd_write = wr_go && paddr == idr_pkg::IDR_OFF_CMD;
	assign cmd_take = cmd_write && state_r == idr_pkg::IDR_IDLE &&
		pwdata[7:0] == idr_pkg::IDR_CMD_IDENTIFY; // see R1
	assign cmd_refuse = cmd_write && !cmd_take;
	assign fill_we = state_r == idr_pkg::IDR_FILL;
	assign fill_last = fill_we && widx_r == LAST;
	assign pop = rd_go && paddr == idr_pkg::IDR_OFF_DATA && drq_r; // see R3
	assign pop_last = pop && rptr_r == LAST;
	assign int_ev = {cmd_refuse, pop_last, ev_ready_d_r};

	idr_wordgen #(
		.SERIAL_STR(SERIAL_STR),
		.FW_STR(FW_STR),
		.MODEL_STR(MODEL_STR)
	) u_gen (
		.idx(widx_r),
		.cfg(cfg_r),
		.word(gen_word)
	);

	idr_buffer #(
		.DW(16),
		.DEPTH(WORDS),
		.AW(8)
	) u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.we(fill_we),
		.waddr(widx_r),
		.wdata(gen_word),
		.raddr(rptr_r),
		.rdata(buf_word)
	);

	// Sequencer: idle, fill the buffer, then hand out words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= idr_pkg::IDR_IDLE;
		end else begin
			case (state_r)
				idr_pkg::IDR_IDLE: begin
					if (cmd_take) begin
						state_r <= idr_pkg::IDR_FILL; // see R1
					end
				end
				idr_pkg::IDR_FILL: begin
					if (fill_last) begin
						state_r <= idr_pkg::IDR_XFER; // see R2
					end
				end
				idr_pkg::IDR_XFER: begin
					if (pop_last) begin
						state_r <= idr_pkg::IDR_IDLE; // see R17
					end
				end
				default: state_r <= idr_pkg::IDR_IDLE;
			endcase
		end
	end

	// Fill index walks the block in ascending order
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			widx_r <= 8'h00;
		end else if (cmd_take) begin
			widx_r <= 8'h00;
		end else if (fill_we) begin
			widx_r <= widx_r + 8'h01; // see R17
		end
	end

	// BSY covers the whole fill; DRQ takes over as it drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsy_r <= 1'b0;
			drq_r <= 1'b0;
			ev_ready_d_r <= 1'b0;
		end else begin
			ev_ready_d_r <= fill_last; // Interrupt follows DRQ, see R2
			if (cmd_take) begin
				bsy_r <= 1'b1; // see R2
			end else if (fill_last) begin
				bsy_r <= 1'b0;
			end
			if (fill_last) begin
				drq_r <= 1'b1; // see R2
			end else if (pop_last) begin
				drq_r <= 1'b0; // see R17
			end
		end
	end

	// Read pointer advances once per data read under DRQ
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rptr_r <= 8'h00;
		end else if (cmd_take) begin
			rptr_r <= 8'h00;
		end else if (pop) begin
			rptr_r <= rptr_r + 8'h01; // see R17
		end
	end

	// Software-set registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_cmd_r <= 8'h00;
			int_mask_r <= idr_pkg::IDR_RST_MASK;
			cfg_r.dflt <= '{idr_pkg::IDR_RST_CYL, idr_pkg::IDR_RST_HEAD, idr_pkg::IDR_RST_SECT};
			cfg_r.cur <= '{idr_pkg::IDR_RST_CYL, idr_pkg::IDR_RST_HEAD, idr_pkg::IDR_RST_SECT};
			cfg_r.mult <= idr_pkg::IDR_RST_MULT;
		end else if (wr_go) begin
			case (paddr)
				idr_pkg::IDR_OFF_CMD: last_cmd_r <= pwdata[7:0];
				idr_pkg::IDR_OFF_INT_MASK: int_mask_r <= pwdata[idr_pkg::IDR_INT_W-1:0];
				idr_pkg::IDR_OFF_DEF_CYL: cfg_r.dflt.cyl <= pwdata[15:0];
				idr_pkg::IDR_OFF_DEF_HS: begin
					cfg_r.dflt.head <= pwdata[idr_pkg::IDR_HS_HEAD_LSB +: 16];
					cfg_r.dflt.sect <= pwdata[idr_pkg::IDR_HS_SECT_LSB +: 16];
				end
				idr_pkg::IDR_OFF_CUR_CYL: cfg_r.cur.cyl <= pwdata[15:0];
				idr_pkg::IDR_OFF_CUR_HS: begin
					cfg_r.cur.head <= pwdata[idr_pkg::IDR_HS_HEAD_LSB +: 16];
					cfg_r.cur.sect <= pwdata[idr_pkg::IDR_HS_SECT_LSB +: 16];
				end
				idr_pkg::IDR_OFF_MULT: cfg_r.mult <= pwdata[7:0];
				default: last_cmd_r <= last_cmd_r;
			endcase
		end
	end

	// Sticky events; a new event beats a same-cycle write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_r <= '0;
		end else if (wr_go && paddr == idr_pkg::IDR_OFF_INT_STAT) begin
			int_stat_r <= int_ev | (int_stat_r & ~pwdata[idr_pkg::IDR_INT_W-1:0]);
		end else begin
			int_stat_r <= int_ev | int_stat_r;
		end
	end

	// Interrupt line, registered so it never glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(int_stat_r & int_mask_r); // see R2
		end
	end

	// Read multiplexer
	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
			idr_pkg::IDR_OFF_CMD: rd_val[7:0] = last_cmd_r;
			idr_pkg::IDR_OFF_STATUS: begin
				rd_val[idr_pkg::IDR_ST_BSY] = bsy_r;
				rd_val[idr_pkg::IDR_ST_DRQ] = drq_r;
				rd_val[idr_pkg::IDR_ST_PTR_LSB +: 8] = rptr_r;
			end
			// Outside DRQ the port reads zero and nothing moves
			idr_pkg::IDR_OFF_DATA: rd_val[15:0] = drq_r ? buf_word : 16'h0000; // see R3
			idr_pkg::IDR_OFF_INT_STAT: rd_val[idr_pkg::IDR_INT_W-1:0] = int_stat_r;
			idr_pkg::IDR_OFF_INT_MASK: rd_val[idr_pkg::IDR_INT_W-1:0] = int_mask_r;
			idr_pkg::IDR_OFF_DEF_CYL: rd_val[15:0] = cfg_r.dflt.cyl;
			idr_pkg::IDR_OFF_DEF_HS: rd_val = {cfg_r.dflt.head, cfg_r.dflt.sect};
			idr_pkg::IDR_OFF_CUR_CYL: rd_val[15:0] = cfg_r.cur.cyl;
			idr_pkg::IDR_OFF_CUR_HS: rd_val = {cfg_r.cur.head, cfg_r.cur.sect};
			idr_pkg::IDR_OFF_MULT: rd_val[7:0] = cfg_r.mult;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// One wait state: the registered buffer word needs a cycle to settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~hit_map(paddr);
			prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rd_val : 32'h0000_0000;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_cmd_accept: assert property (cmd_take |=> bsy_r && state_r == idr_pkg::IDR_FILL) // see R1
		else $error("identify command not accepted");
	chk_bsy_then_drq: assert property ($rose(drq_r) |-> $past(bsy_r) && !bsy_r) // see R2
		else $error("DRQ rose without a preceding busy phase");
	// The ready event is launched on the same edge as DRQ, so it lands in the status a cycle later
	chk_irq_after_drq: assert property ($rose(drq_r) |-> int_ev[0] ##1 int_stat_r[0]) // see R2
		else $error("ready event not one cycle after DRQ");
	chk_fill_span: assert property (cmd_take |-> ##257 $rose(drq_r)) // see R17
		else $error("fill did not take one cycle per word");
	chk_word_gencfg: assert property (fill_we && widx_r == 8'h00 |-> gen_word == 16'h0040) // see R4
		else $error("word 0 wrong");
	chk_def_geom: assert property (fill_we && widx_r == 8'h03 |-> gen_word == cfg_r.dflt.head) // see R5
		else $error("default head word wrong");
	chk_serial_head: assert property (fill_we && widx_r == 8'h0A |-> gen_word == SERIAL_STR[159:144]) // see R6
		else $error("serial first word wrong");
	chk_fw_tail: assert property (fill_we && widx_r == 8'h1A |-> gen_word == FW_STR[15:0]) // see R7
		else $error("firmware last word wrong");
	chk_model_head: assert property (fill_we && widx_r == 8'h1B |-> gen_word == MODEL_STR[319:304]) // see R8
		else $error("model first word wrong");
	chk_mult_word: assert property (fill_we && widx_r == 8'h2F |-> gen_word == {8'h80, cfg_r.mult}) // see R9
		else $error("word 47 wrong");
	chk_cap_word: assert property (fill_we && widx_r == 8'h31 |-> gen_word == 16'h2F00) // see R10
		else $error("word 49 wrong");
	chk_standby_bit: assert property (fill_we && widx_r == 8'h31 |-> gen_word[13]) // see R11
		else $error("standby timer bit clear");
	chk_cap2_word: assert property (fill_we && widx_r == 8'h32 |-> gen_word == 16'h4000) // see R12
		else $error("word 50 wrong");
	chk_pio_word: assert property (fill_we && widx_r == 8'h33 |-> gen_word == 16'h0200) // see R13
		else $error("word 51 wrong");
	chk_valid_word: assert property (fill_we && widx_r == 8'h35 |-> gen_word == 16'h0007) // see R14
		else $error("word 53 wrong");
	chk_cur_geom: assert property (fill_we && widx_r == 8'h38 |-> gen_word == cfg_r.cur.sect) // see R15
		else $error("current sectors word wrong");
	chk_reserved_zero: assert property (fill_we && (widx_r == 8'h04 || widx_r == 8'h30 ||
		widx_r == 8'h34) |-> gen_word == 16'h0000) // see R16
		else $error("reserved word not zero");
	chk_drq_release: assert property (pop_last |=> !drq_r && state_r == idr_pkg::IDR_IDLE) // see R17
		else $error("DRQ held after last word");
	chk_irq_level: assert property (|(int_stat_r & int_mask_r) |=> irq_r) // see R2
		else $error("interrupt line low with an unmasked event pending");
endmodule : idr_top

// file: common/idr_pkg.sv
/*
 Shared constants and types for the identify data responder: APB register
 offsets, field positions, reset values, parameter word layout and states.
 Assumes a 32-bit APB slave with byte addresses and 16-bit parameter words.
*/
// How it works
// R1: Command code ECh requests the parameter block
// R2: Raise BSY, fill buffer, set DRQ, interrupt
// R3: Host reads words through the data port
// R4: Word 0 reads 0040, general configuration
// R5: Words 1, 3, 6 give default geometry
// R6: Words 10 to 19 hold serial string
// R7: Words 23 to 26 hold firmware string
// R8: Words 27 to 46 hold model string
// R9: Word 47 is 80h plus multiple limit
// R10: Word 49 reads 2F00, capability flags
// R11: Word 49 bit 13 marks standard standby timer
// R12: Word 50 reads 4000, bit 14 fixed one
// R13: Word 51 reads 0200, PIO timing mode
// R14: Word 53 reads 0007, validity flags
// R15: Words 54 to 56 give current geometry
// R16: Reserved words read as zero
// R17: 256 words ascending; DRQ clears after last
package idr_pkg;
	// Register byte offsets
	localparam logic [7:0] IDR_OFF_CMD = 8'h00;
	localparam logic [7:0] IDR_OFF_STATUS = 8'h04;
	localparam logic [7:0] IDR_OFF_DATA = 8'h08;
	localparam logic [7:0] IDR_OFF_INT_STAT = 8'h0C;
	localparam logic [7:0] IDR_OFF_INT_MASK = 8'h10;
	localparam logic [7:0] IDR_OFF_DEF_CYL = 8'h14;
	localparam logic [7:0] IDR_OFF_DEF_HS = 8'h18;
	localparam logic [7:0] IDR_OFF_CUR_CYL = 8'h1C;
	localparam logic [7:0] IDR_OFF_CUR_HS = 8'h20;
	localparam logic [7:0] IDR_OFF_MULT = 8'h24;
	// Field positions
	localparam int IDR_ST_BSY = 0;
	localparam int IDR_ST_DRQ = 1;
	localparam int IDR_ST_PTR_LSB = 8;
	localparam int IDR_HS_SECT_LSB = 0;
	localparam int IDR_HS_HEAD_LSB = 16;
	localparam int IDR_INT_DRQ = 0;
	localparam int IDR_INT_DONE = 1;
	localparam int IDR_INT_ERR = 2;
	localparam int IDR_INT_W = 3;
	// Command code of the identify request
	localparam logic [7:0] IDR_CMD_IDENTIFY = 8'hEC;
	// Reset values
	localparam logic [15:0] IDR_RST_CYL = 16'h0400;
	localparam logic [15:0] IDR_RST_HEAD = 16'h0010;
	localparam logic [15:0] IDR_RST_SECT = 16'h003F;
	localparam logic [7:0] IDR_RST_MULT = 8'h10;
	localparam logic [IDR_INT_W-1:0] IDR_RST_MASK = 3'h0;
	// Parameter word indices and fixed values
	localparam int IDR_W_GENCFG = 0;
	localparam int IDR_W_DEF_CYL = 1;
	localparam int IDR_W_SPECCFG = 2;
	localparam int IDR_W_DEF_HEAD = 3;
	localparam int IDR_W_DEF_SECT = 6;
	localparam int IDR_W_SERIAL = 10;
	localparam int IDR_N_SERIAL = 10;
	localparam int IDR_W_FWREV = 23;
	localparam int IDR_N_FWREV = 4;
	localparam int IDR_W_MODEL = 27;
	localparam int IDR_N_MODEL = 20;
	localparam int IDR_W_MULT = 47;
	localparam int IDR_W_CAP = 49;
	localparam int IDR_W_CAP2 = 50;
	localparam int IDR_W_PIO = 51;
	localparam int IDR_W_VALID = 53;
	localparam int IDR_W_CUR_CYL = 54;
	localparam int IDR_W_CUR_HEAD = 55;
	localparam int IDR_W_CUR_SECT = 56;
	localparam logic [15:0] IDR_V_GENCFG = 16'h0040;
	localparam logic [15:0] IDR_V_SPECCFG = 16'hC837;
	localparam logic [7:0] IDR_V_MULT_HI = 8'h80;
	localparam logic [15:0] IDR_V_CAP = 16'h2F00;
	localparam logic [15:0] IDR_V_CAP2 = 16'h4000;
	localparam logic [15:0] IDR_V_PIO = 16'h0200;
	localparam logic [15:0] IDR_V_VALID = 16'h0007;
	// Drive geometry triple
	typedef struct packed {
		logic [15:0] cyl;
		logic [15:0] head;
		logic [15:0] sect;
	} idr_geom_s;
	// Software-set content of the parameter block
	typedef struct packed {
		idr_geom_s dflt;
		idr_geom_s cur;
		logic [7:0] mult;
	} idr_cfg_s;
	// Command sequencer states
	typedef enum logic [1:0] {
		IDR_IDLE,
		IDR_FILL,
		IDR_XFER
	} idr_state_e;
endpackage : idr_pkg

// file: src/idr_buffer.sv
/*
 Sector buffer: one write port, one registered read port.
 Assumes a single clock; contents are not reset, the fill writes every word.
*/
`timescale 1ns/1ps
module idr_buffer #(
	parameter int DW = 16,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH]; // Word storage

	generate
		if (DEPTH > (1 << AW)) begin : g_bad_depth
			$error("idr_buffer: DEPTH does not fit AW");
		end
	endgenerate

	// Write port
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read keeps the read path off the bus decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : idr_buffer

// file: src/idr_wordgen.sv
/*
 Parameter word generator: maps a word index to its 16-bit value.
 Assumes strings are packed first character in the top byte.
*/
`timescale 1ns/1ps
module idr_wordgen #(
	parameter logic [159:0] SERIAL_STR = "0123456789ABCDEFGHIJ",
	parameter logic [63:0] FW_STR = "REV00001",
	parameter logic [319:0] MODEL_STR = {"GENERIC DISK DRIVE  ", "                    "}
) (
	input wire logic [7:0] idx,
	input wire idr_pkg::idr_cfg_s cfg,
	output logic [15:0] word
);
	// Word i of an n-word string, first two characters in word 0
	function automatic logic [15:0] str_word(input logic [319:0] s, input int n, input int i);
		str_word = s[n*16-1-i*16 -: 16];
	endfunction : str_word

	// Index decode; anything not named stays zero
	always_comb begin
		word = 16'h0000; // see R16
		if (idx >= 8'(idr_pkg::IDR_W_SERIAL) &&
			idx < 8'(idr_pkg::IDR_W_SERIAL + idr_pkg::IDR_N_SERIAL)) begin
			word = str_word({160'h0, SERIAL_STR}, idr_pkg::IDR_N_SERIAL,
				int'(idx) - idr_pkg::IDR_W_SERIAL); // see R6
		end else if (idx >= 8'(idr_pkg::IDR_W_FWREV) &&
			idx < 8'(idr_pkg::IDR_W_FWREV + idr_pkg::IDR_N_FWREV)) begin
			word = str_word({256'h0, FW_STR}, idr_pkg::IDR_N_FWREV,
				int'(idx) - idr_pkg::IDR_W_FWREV); // see R7
		end else if (idx >= 8'(idr_pkg::IDR_W_MODEL) &&
			idx < 8'(idr_pkg::IDR_W_MODEL + idr_pkg::IDR_N_MODEL)) begin
			word = str_word(MODEL_STR, idr_pkg::IDR_N_MODEL,
				int'(idx) - idr_pkg::IDR_W_MODEL); // see R8
		end else begin
			case (int'(idx))
				idr_pkg::IDR_W_GENCFG: word = idr_pkg::IDR_V_GENCFG; // see R4
				idr_pkg::IDR_W_DEF_CYL: word = cfg.dflt.cyl; // see R5
				idr_pkg::IDR_W_SPECCFG: word = idr_pkg::IDR_V_SPECCFG;
				idr_pkg::IDR_W_DEF_HEAD: word = cfg.dflt.head; // see R5
				idr_pkg::IDR_W_DEF_SECT: word = cfg.dflt.sect; // see R5
				idr_pkg::IDR_W_MULT: word = {idr_pkg::IDR_V_MULT_HI, cfg.mult}; // see R9
				idr_pkg::IDR_W_CAP: word = idr_pkg::IDR_V_CAP; // see R10 and R11
				idr_pkg::IDR_W_CAP2: word = idr_pkg::IDR_V_CAP2; // see R12
				idr_pkg::IDR_W_PIO: word = idr_pkg::IDR_V_PIO; // see R13
				idr_pkg::IDR_W_VALID: word = idr_pkg::IDR_V_VALID; // see R14
				idr_pkg::IDR_W_CUR_CYL: word = cfg.cur.cyl; // see R15
				idr_pkg::IDR_W_CUR_HEAD: word = cfg.cur.head; // see R15
				idr_pkg::IDR_W_CUR_SECT: word = cfg.cur.sect; // see R15
				default: word = 16'h0000; // see R16
			endcase
		end
	end
endmodule : idr_wordgen

// file: verification/idr_host_model.sv
/*
 Host model: the APB master that reads the task file and drains the block.
 Assumes the responder answers every transfer with pready; hangs are cut by the bench.
*/
`timescale 1ns/1ps
module idr_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Words captured by the last block read
	logic [15:0] blk [256];

	// Bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// One transfer; the request stands until pready is seen at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No latency assumed: wait for the answer itself
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines flip so a stale value can never pass for a fresh one
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer

	// Drain the block lowest word first; no DRQ check here, the caller waits for it
	task read_block();
		logic [31:0] q;
		logic e;
		for (int i = 0; i < 256; i++) begin
			xfer(1'b0, idr_pkg::IDR_OFF_DATA, 32'h00000000, q, e);
			blk[i] = q[15:0];
		end
	endtask : read_block
endmodule : idr_host_model

// file: verification/test_identify_data_responder.sv
/*
 Bench: resets the responder, checks its registers, refusals and interrupt,
 then runs one identify and compares all 256 words. Assumes the host model.
*/
`timescale 1ns/1ps
module test_identify_data_responder;
	// Strings of our own so expected words come from the bench alone
	localparam logic [159:0] SER = "SN-ABCDEFGHIJKLMNOPQ";
	localparam logic [63:0] FW = "FW-01.23";
	localparam logic [319:0] MDL = {"QA BENCH DRIVE MODEL", "QA BENCH DRIVE MODEL"};
	// Geometry programmed before the identify
	localparam logic [15:0] DCYL = 16'h1234;
	localparam logic [15:0] DHEAD = 16'h0008;
	localparam logic [15:0] DSECT = 16'h0020;
	localparam logic [15:0] CCYL = 16'h0ABC;
	localparam logic [15:0] CHEAD = 16'h0004;
	localparam logic [15:0] CSECT = 16'h0011;
	localparam logic [7:0] MULT = 8'h08;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e;
	int error_cnt = 0;
	int checked = 0;

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	idr_top #(.WORDS(256), .SERIAL_STR(SER), .FW_STR(FW), .MODEL_STR(MDL)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));

	idr_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// Single compare for every result, widened to 32 bits
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Register read with expected data and no error
	task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		host.xfer(1'b0, a, 32'h00000000, q, e);
		chk(what, exp, q);
		chk(what, 32'h00000000, {31'h0, e});
	endtask : rd

	// Register write; every mapped write answers without error
	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
		chk("write err", 32'h00000000, {31'h0, e});
	endtask : wr

	// Only BSY and DRQ matter here; the pointer field is left aside
	task status(input logic [1:0] exp, input string what);
		host.xfer(1'b0, idr_pkg::IDR_OFF_STATUS, 32'h00000000, q, e);
		chk(what, {30'h0, exp}, {30'h0, q[1:0]});
	endtask : status

	// Expected parameter word; strings carry the first character high
	function automatic logic [15:0] exp_word(input int i);
		case (i)
			0: return 16'h0040;
			1: return DCYL;
			2: return 16'hC837;
			3: return DHEAD;
			6: return DSECT;
			47: return {8'h80, MULT};
			49: return 16'h2F00;
			50: return 16'h4000;
			51: return 16'h0200;
			53: return 16'h0007;
			54: return CCYL;
			55: return CHEAD;
			56: return CSECT;
			default: begin
			end
		endcase
		if (i >= 10 && i <= 19) return SER[159 - 16 * (i - 10) -: 16];
		if (i >= 23 && i <= 26) return FW[63 - 16 * (i - 23) -: 16];
		if (i >= 27 && i <= 46) return MDL[319 - 16 * (i - 27) -: 16];
		return 16'h0000;
	endfunction : exp_word

	// Verdict; reached from the main sequence or the watchdog
	task summarize();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values
		rd(idr_pkg::IDR_OFF_DEF_CYL, 32'h00000400, "def_cyl");
		rd(idr_pkg::IDR_OFF_DEF_HS, 32'h0010003F, "def_hs");
		rd(idr_pkg::IDR_OFF_CUR_CYL, 32'h00000400, "cur_cyl");
		rd(idr_pkg::IDR_OFF_CUR_HS, 32'h0010003F, "cur_hs");
		rd(idr_pkg::IDR_OFF_MULT, 32'h00000010, "mult");
		rd(idr_pkg::IDR_OFF_INT_MASK, 32'h00000000, "int_mask");
		status(2'h0, "status idle");
		// Unmapped address answers with an error and zero data
		host.xfer(1'b0, 8'h3C, 32'h00000000, q, e);
		chk("unmapped data", 32'h00000000, q);
		chk("unmapped err", 32'h00000001, {31'h0, e});
		rd(idr_pkg::IDR_OFF_DATA, 32'h00000000, "data no drq");
		// Foreign code refused, then cleared by writing one
		wr(idr_pkg::IDR_OFF_CMD, 32'h000000E4);
		rd(idr_pkg::IDR_OFF_INT_STAT, 32'h00000004, "refused");
		wr(idr_pkg::IDR_OFF_INT_STAT, 32'h00000004);
		rd(idr_pkg::IDR_OFF_INT_STAT, 32'h00000000, "w1c");
		// Program geometry and multiple limit
		wr(idr_pkg::IDR_OFF_DEF_CYL, {16'h0, DCYL});
		wr(idr_pkg::IDR_OFF_DEF_HS, {DHEAD, DSECT});
		wr(idr_pkg::IDR_OFF_CUR_CYL, {16'h0, CCYL});
		wr(idr_pkg::IDR_OFF_CUR_HS, {CHEAD, CSECT});
		wr(idr_pkg::IDR_OFF_MULT, {24'h0, MULT});
		// Identify: busy at once, a second command refused meanwhile
		wr(idr_pkg::IDR_OFF_CMD, 32'h000000EC);
		status(2'h1, "busy");
		wr(idr_pkg::IDR_OFF_CMD, 32'h000000EC);
		rd(idr_pkg::IDR_OFF_INT_STAT, 32'h00000004, "busy refused");
		rd(idr_pkg::IDR_OFF_CMD, 32'h000000EC, "last cmd");
		wr(idr_pkg::IDR_OFF_INT_STAT, 32'h00000004);
		q = 32'h00000000;
		while (q[1] !== 1'b1) host.xfer(1'b0, idr_pkg::IDR_OFF_STATUS, 32'h0, q, e);
		chk("drq without bsy", 32'h00000002, {30'h0, q[1:0]});
		rd(idr_pkg::IDR_OFF_INT_STAT, 32'h00000001, "drq event");
		chk("irq masked", 32'h00000000, {31'h0, irq});
		wr(idr_pkg::IDR_OFF_INT_MASK, 32'h00000001);
		repeat (2) @(posedge pclk);
		chk("irq unmasked", 32'h00000001, {31'h0, irq});
		host.read_block();
		for (int i = 0; i < 256; i++) begin
			chk($sformatf("word %0d", i), {16'h0, exp_word(i)}, {16'h0, host.blk[i]});
		end
		status(2'h0, "drq after last");
		rd(idr_pkg::IDR_OFF_INT_STAT, 32'h00000003, "last word event");
		wr(idr_pkg::IDR_OFF_INT_STAT, 32'h00000007);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'h00000000, {31'h0, irq});
		rd(idr_pkg::IDR_OFF_DATA, 32'h00000000, "data after drain");
		summarize();
	end

	// Watchdog: the whole run needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
endmodule : test_identify_data_responder
